//--- multichannel_dma_control.sv
// Purpose: channel control and single data mover for a 32-channel dma engine
// Assumes: read port returns one response per accepted request
// Notes: one read outstanding; writes drain through a fifo
`timescale 1ns/1ps

module beat_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  always_comb begin
    in_ready = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    out_data = mem_reg[rp_reg];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
    end
    if (pop) begin
      rp_next = (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule

module multichannel_dma_control #(
  parameter int DEPTH = dma_ctl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic [4:0] cfg_chan,
  input wire dma_ctl_pkg::chan_cfg_s cfg_data,
  input wire dma_ctl_pkg::engine_control_s engine_control,
  input wire logic [31:0] req_enable_set,
  input wire logic [31:0] req_enable_clear,
  input wire logic [31:0] channel_error_irq_enable_map,
  input wire logic [31:0] sw_start,
  input wire logic [31:0] irq_clear,
  input wire logic [31:0] error_clear,
  input wire logic [dma_ctl_pkg::NSRC-1:0] periph_req,
  output logic rd_req_valid,
  input wire logic rd_ready,
  output logic [31:0] rd_addr,
  input wire logic rd_resp_valid,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output dma_ctl_pkg::wr_beat_s wr_beat,
  output logic coherency_global_output,
  output logic [31:0] channel_request_enable_map,
  output logic [31:0] channel_irq_pending_map,
  output logic [31:0] channel_error_map,
  output logic [31:0] error_irq,
  output dma_ctl_pkg::err_status_s last_error_status,
  output logic busy,
  output logic [4:0] active_chan
);
  dma_ctl_pkg::chan_cfg_s cfg_reg [dma_ctl_pkg::NCH];
  dma_ctl_pkg::chan_cfg_s cfg_next [dma_ctl_pkg::NCH];
  dma_ctl_pkg::engine_control_s engine_control_reg;
  dma_ctl_pkg::eng_state_e state_reg, state_next;
  dma_ctl_pkg::err_status_s last_err_reg, last_err_next;
  dma_ctl_pkg::wr_beat_s wr_beat_reg, wr_beat_next;
  logic [31:0] pend_reg, pend_next, req_en_reg, req_en_next;
  logic [31:0] irq_reg, irq_next, err_reg, err_next, err_irq_reg, err_irq_next;
  logic [31:0] hw_set, link_set, done_set, fail_set, grant_vec;
  logic [31:0] src_reg, src_next, dst_reg, dst_next, rd_addr_reg, rd_addr_next;
  logic [15:0] left_reg, left_next;
  logic [4:0] act_reg, act_next, rr_reg, rr_next, win;
  logic [5:0] best_key, key;
  logic [4:0] idx;
  logic found, failed_reg, failed_next, rd_valid_reg, rd_valid_next;
  logic wr_valid_reg, wr_valid_next, glob_reg, busy_reg;
  logic f_in_ready, f_out_valid, f_out_ready, f_push;
  dma_ctl_pkg::wr_beat_s f_out_data;

  // each channel's request routes through its own source selector
  for (genvar i = 0; i < dma_ctl_pkg::NCH; i++) begin : g_route
    always_comb begin
      hw_set[i] = req_en_reg[i] && ((cfg_reg[i].source >= dma_ctl_pkg::ALWAYS_FIRST)
                  || periph_req[cfg_reg[i].source]) && !(state_reg != dma_ctl_pkg::ST_IDLE && act_reg == 5'(i));
    end
  end

  // arbitration: with round robin off, group 1 (upper sixteen) outranks group 0; ties go to the lower index
  always_comb begin
    found = 1'b0;
    win = dma_ctl_pkg::CHAN_RESET;
    best_key = '0;
    key = '0;
    idx = '0;
    if (engine_control_reg.round_robin_channel_arb) begin
      for (int k = 1; k <= dma_ctl_pkg::NCH; k++) begin
        idx = rr_reg + 5'(k);
        if (pend_reg[idx] && !found) begin
          found = 1'b1;
          win = idx;
        end
      end
    end else begin
      for (int i = 0; i < dma_ctl_pkg::NCH; i++) begin
        key = {i[4], cfg_reg[i].prio, 1'b1};
        if (pend_reg[i] && (!found || key > best_key)) begin
          found = 1'b1;
          win = 5'(i);
          best_key = key;
        end
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    act_next = act_reg;
    rr_next = rr_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    left_next = left_reg;
    failed_next = failed_reg;
    rd_valid_next = rd_valid_reg;
    rd_addr_next = rd_addr_reg;
    last_err_next = last_err_reg;
    grant_vec = '0;
    link_set = '0;
    done_set = '0;
    fail_set = '0;
    f_push = 1'b0;
    unique case (state_reg)
      dma_ctl_pkg::ST_IDLE: begin
        if (found && !engine_control_reg.halt) begin
          grant_vec[win] = 1'b1;
          act_next = win;
          rr_next = win;
          src_next = cfg_reg[win].src_addr;
          dst_next = cfg_reg[win].dst_addr;
          left_next = cfg_reg[win].count;
          failed_next = 1'b0;
          state_next = dma_ctl_pkg::ST_ISSUE;
        end
      end
      dma_ctl_pkg::ST_ISSUE: begin
        if (rd_valid_reg) begin
          if (rd_ready) begin
            rd_valid_next = 1'b0;
            state_next = dma_ctl_pkg::ST_WAIT;
          end
        end else if (left_reg == '0) begin
          state_next = dma_ctl_pkg::ST_FINISH;
        end else if (f_in_ready) begin
          // one read in flight, so a free slot now is still free at the answer
          rd_valid_next = 1'b1;
          rd_addr_next = src_reg;
        end
      end
      dma_ctl_pkg::ST_WAIT: begin
        if (rd_resp_valid) begin
          if (rd_err) begin
            fail_set[act_reg] = 1'b1;
            last_err_next = '{valid: 1'b1, chan: act_reg, addr: src_reg};
            failed_next = 1'b1;
            state_next = dma_ctl_pkg::ST_FINISH;
          end else begin
            f_push = 1'b1;
            src_next = src_reg + 32'h0000_0004;
            dst_next = dst_reg + 32'h0000_0004;
            left_next = left_reg - 16'h0001;
            state_next = dma_ctl_pkg::ST_ISSUE;
          end
        end
      end
      dma_ctl_pkg::ST_FINISH: begin
        if (!failed_reg) begin
          done_set[act_reg] = 1'b1;
          if (cfg_reg[act_reg].link_en) begin
            link_set[cfg_reg[act_reg].link_ch] = 1'b1;
          end
        end
        state_next = dma_ctl_pkg::ST_IDLE;
      end
    endcase
  end

  // software and hardware flags: a set in the same cycle as a clear wins, except a hardware request against its own grant
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr) begin
      cfg_next[cfg_chan] = cfg_data;
    end
    pend_next = (pend_reg & ~grant_vec) | sw_start | link_set | (hw_set & ~grant_vec);
    req_en_next = (req_en_reg & ~req_enable_clear & ~done_set) | req_enable_set;
    irq_next = (irq_reg & ~irq_clear) | done_set;
    err_next = (err_reg & ~error_clear) | fail_set;
    err_irq_next = err_reg & channel_error_irq_enable_map;
    f_out_ready = !wr_valid_reg || wr_ready;
    wr_valid_next = wr_valid_reg;
    wr_beat_next = wr_beat_reg;
    if (f_out_ready) begin
      wr_valid_next = f_out_valid;
      wr_beat_next = f_out_data;
    end
  end

  beat_fifo #(
    .WIDTH($bits(dma_ctl_pkg::wr_beat_s)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(f_push),
    .in_ready(f_in_ready),
    .in_data({dst_reg, rd_data}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  always_ff @(posedge clk) begin
    cfg_reg <= cfg_next;
    if (rst) begin
      engine_control_reg <= '0;
      state_reg <= dma_ctl_pkg::ST_IDLE;
      act_reg <= dma_ctl_pkg::CHAN_RESET;
      rr_reg <= dma_ctl_pkg::CHAN_RESET;
      src_reg <= '0;
      dst_reg <= '0;
      left_reg <= '0;
      failed_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_addr_reg <= '0;
      last_err_reg <= '0;
      pend_reg <= dma_ctl_pkg::MAP_RESET;
      req_en_reg <= dma_ctl_pkg::MAP_RESET;
      irq_reg <= dma_ctl_pkg::MAP_RESET;
      err_reg <= dma_ctl_pkg::MAP_RESET;
      err_irq_reg <= dma_ctl_pkg::MAP_RESET;
      wr_valid_reg <= 1'b0;
      wr_beat_reg <= '0;
      glob_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      engine_control_reg <= engine_control;
      state_reg <= state_next;
      act_reg <= act_next;
      rr_reg <= rr_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      left_reg <= left_next;
      failed_reg <= failed_next;
      rd_valid_reg <= rd_valid_next;
      rd_addr_reg <= rd_addr_next;
      last_err_reg <= last_err_next;
      pend_reg <= pend_next;
      req_en_reg <= req_en_next;
      irq_reg <= irq_next;
      err_reg <= err_next;
      err_irq_reg <= err_irq_next;
      wr_valid_reg <= wr_valid_next;
      wr_beat_reg <= wr_beat_next;
      glob_reg <= engine_control.global_writes;
      busy_reg <= (state_next != dma_ctl_pkg::ST_IDLE);
    end
  end

  assign rd_req_valid = rd_valid_reg;
  assign rd_addr = rd_addr_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_beat = wr_beat_reg;
  assign coherency_global_output = glob_reg;
  assign channel_request_enable_map = req_en_reg;
  assign channel_irq_pending_map = irq_reg;
  assign channel_error_map = err_reg;
  assign error_irq = err_irq_reg;
  assign last_error_status = last_err_reg;
  assign busy = busy_reg;
  assign active_chan = act_reg;

  // helper: a pending channel that outranks the fixed-priority winner
  logic beaten;
  always_comb begin
    beaten = 1'b0;
    for (int i = 0; i < dma_ctl_pkg::NCH; i++) begin
      if (pend_reg[i] && ({i[4], cfg_reg[i].prio} > {win[4], cfg_reg[win].prio})) begin
        beaten = 1'b1;
      end
    end
  end

  sequence s_read_error;
    state_reg == dma_ctl_pkg::ST_WAIT && rd_resp_valid && rd_err;
  endsequence
  sequence s_clean_finish;
    state_reg == dma_ctl_pkg::ST_FINISH && !failed_reg;
  endsequence

  property p_err_irq;
    @(posedge clk) disable iff (rst) !$past(rst) |-> error_irq == ($past(err_reg) & $past(channel_error_irq_enable_map));
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq not gated by flag and enable");

  property p_hw_gate;
    @(posedge clk) disable iff (rst) (pend_reg & ~$past(pend_reg) & ~$past(sw_start | link_set | req_en_reg)) == '0;
  endproperty
  a_hw_gate: assert property (p_hw_gate) else $error("hardware request taken while disabled");

  property p_done_irq;
    @(posedge clk) disable iff (rst) s_clean_finish |=> irq_reg[$past(act_reg)] && state_reg == dma_ctl_pkg::ST_IDLE;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion did not raise pending irq");

  property p_link;
    @(posedge clk) disable iff (rst) s_clean_finish and cfg_reg[act_reg].link_en |=> pend_reg[$past(cfg_reg[act_reg].link_ch)];
  endproperty
  a_link: assert property (p_link) else $error("linked channel not started");

  property p_err_record;
    @(posedge clk) disable iff (rst) s_read_error |=> err_reg[$past(act_reg)] && last_err_reg.valid
      && last_err_reg.chan == $past(act_reg) ##1 !irq_reg[$past(act_reg, 2)] || $past(irq_reg[act_reg]);
  endproperty
  a_err_record: assert property (p_err_record) else $error("error not recorded");

  property p_fixed_prio;
    @(posedge clk) disable iff (rst) state_reg == dma_ctl_pkg::ST_IDLE && found && !engine_control_reg.halt
      && !engine_control_reg.round_robin_channel_arb |-> !beaten ##1 act_reg == $past(win);
  endproperty
  a_fixed_prio: assert property (p_fixed_prio) else $error("fixed priority winner wrong");

  property p_read_hold;
    @(posedge clk) disable iff (rst) rd_req_valid && !rd_ready |=> rd_req_valid && $stable(rd_addr);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read request dropped before accept");

  property p_global;
    @(posedge clk) disable iff (rst) !$past(rst) |-> coherency_global_output == $past(engine_control.global_writes);
  endproperty
  a_global: assert property (p_global) else $error("global write marking lags");
endmodule

//--- dma_ctl_pkg.sv
// Purpose: shared constants and types for the multichannel dma control block
// Assumes: one clock, synchronous active-high reset
// Notes: channel descriptors are loaded one channel at a time over a config strobe
// Operation
// - thirty-two independent channels each move words from a source address to a destination address.
// - several channels may be pending together or run one after another as a chain.
// - when a channel's block completes with linking on, its link target channel is set pending.
// - each channel selects any of peripheral request lines 0 to 47 through its source field.
// - source numbers at or above the always-requestor base request without any handshake.
// - the last error status records the channel and address of the most recent error.
// - the request enable map gates each channel's hardware request.
// - the error interrupt enable map enables each channel's error interrupt.
// - the interrupt pending map shows which channels have finished a block.
// - the error map shows which channels have met an error.
// - the coherency global output marks every engine write as global.
// - with round robin arbitration off, each channel's priority orders it within its group.
package dma_ctl_pkg;
  localparam int NCH = 32;
  localparam int NSRC = 64;
  localparam logic [5:0] ALWAYS_FIRST = 6'h30;
  localparam int FIFO_DEPTH = 16;
  localparam logic [31:0] MAP_RESET = 32'h0000_0000;
  localparam logic [4:0] CHAN_RESET = 5'h00;

  typedef struct packed {
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [15:0] count;
    logic [5:0] source;
    logic link_en;
    logic [4:0] link_ch;
    logic [3:0] prio;
  } chan_cfg_s;

  typedef struct packed {
    logic round_robin_channel_arb;
    logic halt;
    logic global_writes;
  } engine_control_s;

  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [31:0] addr;
  } err_status_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } wr_beat_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_FINISH = 4'b1000
  } eng_state_e;
endpackage

//--- mem_responder.sv
// Purpose: memory side of the engine's read port, answering word reads
// Assumes: one read outstanding at a time
// Notes: top nibble E answers with an error; slow mode adds wait states
`timescale 1ns/1ps
module mem_responder (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic rd_req_valid,
  input wire logic [31:0] rd_addr,
  output logic rd_ready,
  output logic rd_resp_valid,
  output logic rd_err,
  output logic [31:0] rd_data
);
  logic [31:0] addr_q;
  logic pend;
  int wait_n;
  always @(posedge clk) begin
    rd_ready <= 1'h0;
    rd_resp_valid <= 1'h0;
    rd_err <= 1'h0;
    // idle data toggles so a stale word never passes for a fresh one
    rd_data <= ~rd_data;
    if (rst) begin
      pend <= 1'h0;
      rd_data <= 32'h0;
    end else if (pend && wait_n == 0) begin
      rd_resp_valid <= 1'h1;
      rd_err <= addr_q[31:28] == 4'hE;
      rd_data <= addr_q ^ 32'h5A5A_A5A5;
      pend <= 1'h0;
    end else if (pend) begin
      wait_n <= wait_n - 1;
    end else if (rd_req_valid && rd_ready) begin
      addr_q <= rd_addr;
      pend <= 1'h1;
      wait_n <= slow ? 3 : 0;
    end else if (rd_req_valid) begin
      rd_ready <= !slow || !rd_data[0];
    end
  end
endmodule

//--- multichannel_dma_control_test.sv
// Purpose: self-checking bench for the multichannel dma control block
// Assumes: memory word at address a holds a xor 5A5AA5A5
// Notes: expected writes are queued in order and matched beat by beat
`timescale 1ns/1ps
module multichannel_dma_control_test;
  logic clk = 0, rst = 1, cfg_wr = 0, wr_ready = 0, slow = 0, stall = 0;
  logic [4:0] cfg_chan = 5'h00;
  dma_ctl_pkg::chan_cfg_s cfg_data = '0;
  dma_ctl_pkg::engine_control_s engine_control = '0;
  logic [31:0] en_set = 0, en_clr = 0, irq_en = 0, sw_start = 0, irq_clr = 0, err_clr = 0;
  logic [63:0] periph_req = 64'h0;
  logic rd_req_valid, rd_ready, rd_resp_valid, rd_err, wr_valid, coh, busy;
  logic [31:0] rd_addr, rd_data, req_map, irq_map, err_map, error_irq, exp_irq, s;
  logic [4:0] active_chan;
  dma_ctl_pkg::wr_beat_s wr_beat;
  dma_ctl_pkg::err_status_s last_err;
  logic [63:0] exp_q[$];
  integer n_errors = 0, n_tests = 0, seed = 78, n_rd = 0;

  initial forever #2 clk = ~clk;

  multichannel_dma_control u_multichannel_dma_control (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_chan(cfg_chan), .cfg_data(cfg_data), .engine_control(engine_control), .req_enable_set(en_set),
    .req_enable_clear(en_clr), .channel_error_irq_enable_map(irq_en), .sw_start(sw_start),
    .irq_clear(irq_clr), .error_clear(err_clr), .periph_req(periph_req), .rd_req_valid(rd_req_valid),
    .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_resp_valid(rd_resp_valid), .rd_err(rd_err),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_beat(wr_beat),
    .coherency_global_output(coh), .channel_request_enable_map(req_map), .channel_irq_pending_map(irq_map),
    .channel_error_map(err_map), .error_irq(error_irq), .last_error_status(last_err), .busy(busy),
    .active_chan(active_chan));

  mem_responder u_mem_responder (.clk(clk), .rst(rst), .slow(slow), .rd_req_valid(rd_req_valid),
    .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_resp_valid(rd_resp_valid), .rd_err(rd_err), .rd_data(rd_data));

  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
  endtask

  // random stall keeps the write side honest; stall holds it off entirely
  always @(posedge clk) begin
    wr_ready <= !stall && (($random(seed) & 1) != 0);
    if (!rst && rd_req_valid && rd_ready) n_rd++;
    if (!rst && wr_valid && wr_ready) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected write beat");
      end else begin
        check(wr_beat === exp_q[0], "write beat mismatch");
        void'(exp_q.pop_front());
      end
    end
  end

  task automatic cfg(input logic [4:0] ch, input logic [31:0] src, dst, input logic [15:0] cnt,
    input logic [5:0] sr, input logic len, input logic [4:0] lch, input logic [3:0] pr);
    cfg_chan <= ch;
    cfg_data <= {src, dst, cnt, sr, len, lch, pr};
    cfg_wr <= 1'h1;
    tick();
    cfg_wr <= 1'h0;
    tick();
  endtask

  // model of one block: word n goes from src+4n to dst+4n
  task automatic expect_block(input logic [31:0] src, dst, input int cnt, input int ch);
    for (int n = 0; n < cnt; n++) exp_q.push_back({dst + 32'(n * 4), (src + 32'(n * 4)) ^ 32'h5A5A_A5A5});
    exp_irq[ch] = 1'h1;
  endtask

  task automatic ctl(input logic [31:0] st, set, clr, ic, ec);
    sw_start <= st;
    en_set <= set;
    en_clr <= clr;
    irq_clr <= ic;
    err_clr <= ec;
    tick();
    sw_start <= 32'h0;
    en_set <= 32'h0;
    en_clr <= 32'h0;
    irq_clr <= 32'h0;
    err_clr <= 32'h0;
    tick();
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    while ((busy !== 1'h0 || exp_q.size() != 0) && k < 3000) begin
      tick();
      k++;
    end
    check(k < 3000, "block did not complete");
    tick(3);
    check(irq_map === exp_irq, "irq pending map");
  endtask

  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    exp_irq = 32'h0;
    tick(4);
    rst <= 1'h0;
    tick();
    // full buffer must hold back reads while writes stall
    slow <= 1'h1;
    stall <= 1'h1;
    cfg(5'h03, 32'h0000_1000, 32'h0008_0000, 16'h0014, 6'h00, 0, 5'h00, 4'h0);
    expect_block(32'h0000_1000, 32'h0008_0000, 20, 3);
    ctl(32'h8, 0, 0, 0, 0);
    tick(400);
    check(n_rd >= dma_ctl_pkg::FIFO_DEPTH && n_rd < 20, "reads not held back by full buffer");
    stall <= 1'h0;
    slow <= 1'h0;
    wait_done();
    // chained pair, random addresses
    s = $random(seed) & 32'h0FFF_FFFC;
    cfg(5'h05, s, 32'h0009_0000, 16'h0003, 6'h00, 1, 5'h06, 4'h0);
    cfg(5'h06, s + 32'h100, 32'h000A_0000, 16'h0002, 6'h00, 0, 5'h00, 4'h0);
    expect_block(s, 32'h0009_0000, 3, 5);
    expect_block(s + 32'h100, 32'h000A_0000, 2, 6);
    ctl(32'h20, 0, 0, 0, 0);
    wait_done();
    // three pending at once, fixed priority decides order
    engine_control.halt <= 1'h1;
    cfg(5'h01, 32'h100, 32'h0B_0000, 16'h0002, 6'h00, 0, 5'h00, 4'h2);
    cfg(5'h02, 32'h200, 32'h0C_0000, 16'h0002, 6'h00, 0, 5'h00, 4'h5);
    cfg(5'h11, 32'h300, 32'h0D_0000, 16'h0002, 6'h00, 0, 5'h00, 4'h0);
    expect_block(32'h300, 32'h0D_0000, 2, 17);
    expect_block(32'h200, 32'h0C_0000, 2, 2);
    expect_block(32'h100, 32'h0B_0000, 2, 1);
    ctl(32'h0002_0006, 0, 0, 0, 0);
    engine_control.halt <= 1'h0;
    wait_done();
    // routed request: set and clear enable, refused while clear, runs once set
    cfg(5'h0A, 32'h400, 32'h0E_0000, 16'h0002, 6'h05, 0, 5'h00, 4'h0);
    ctl(0, 32'h400, 0, 0, 0);
    check(req_map[10] === 1'h1, "enable set");
    ctl(0, 0, 32'h400, 0, 0);
    check(req_map[10] === 1'h0, "enable clear");
    periph_req[5] <= 1'h1;
    tick(20);
    check(busy === 1'h0 && irq_map[10] === 1'h0, "request ran while disabled");
    expect_block(32'h400, 32'h0E_0000, 2, 10);
    ctl(0, 32'h400, 0, 0, 0);
    wait_done();
    check(req_map[10] === 1'h0, "enable kept after completion");
    periph_req[5] <= 1'h0;
    // always requestors at both ends of their range
    cfg(5'h0C, 32'h500, 32'h0F_0000, 16'h0001, 6'h30, 0, 5'h00, 4'h0);
    cfg(5'h1F, 32'h600, 32'h10_0000, 16'h0001, 6'h3F, 0, 5'h00, 4'h0);
    expect_block(32'h600, 32'h10_0000, 1, 31);
    expect_block(32'h500, 32'h0F_0000, 1, 12);
    ctl(0, 32'h8000_1000, 0, 0, 0);
    wait_done();
    // read error, interrupt gated by its enable
    cfg(5'h14, 32'hE000_0040, 32'h11_0000, 16'h0002, 6'h00, 0, 5'h00, 4'h0);
    ctl(32'h0010_0000, 0, 0, 0, 0);
    tick(30);
    check(err_map === 32'h0010_0000 && error_irq === 32'h0, "error map");
    check(last_err === {1'h1, 5'h14, 32'hE000_0040}, "last error status");
    check(active_chan === 5'h14, "active channel");
    check(irq_map === exp_irq, "irq set by error");
    irq_en <= 32'h0010_0000;
    tick(3);
    check(error_irq === 32'h0010_0000, "error irq not raised");
    ctl(0, 0, 0, 0, 32'h0010_0000);
    tick(2);
    check(err_map === 32'h0 && error_irq === 32'h0, "error clear");
    ctl(0, 0, 0, exp_irq, 0);
    exp_irq = 32'h0;
    tick(2);
    check(irq_map === 32'h0, "irq clear");
    // round robin: the channel after the last grant goes first, whatever the priorities
    engine_control <= '{round_robin_channel_arb: 1'h1, halt: 1'h1, global_writes: 1'h0};
    cfg(5'h15, 32'h700, 32'h12_0000, 16'h0002, 6'h00, 0, 5'h00, 4'h0);
    cfg(5'h1E, 32'h800, 32'h13_0000, 16'h0002, 6'h00, 0, 5'h00, 4'h9);
    expect_block(32'h700, 32'h12_0000, 2, 21);
    expect_block(32'h800, 32'h13_0000, 2, 30);
    ctl(32'h4020_0000, 0, 0, 0, 0);
    engine_control.halt <= 1'h0;
    wait_done();
    engine_control.global_writes <= 1'h1;
    tick(3);
    check(coh === 1'h1, "global writes on");
    engine_control.global_writes <= 1'h0;
    tick(3);
    check(coh === 1'h0, "global writes off");
    results();
  end

  initial begin
    tick(10000);
    n_errors++;
    results();
  end
endmodule
